// ### csfp_pkg.sv
// Shared constants and types for the cache snoop and line-fill pin control.
// Assumes a single bus clock domain; pins are synchronised before use.
package csfp_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int LINE_OFS = 5;
  localparam logic [2:0] BURST_BEATS = 3'h4;
  localparam logic [2:0] BEAT_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // Line states and bus cycle states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CSFP_LINE_INVALID = 2'b00,
    CSFP_LINE_SHARED = 2'b01,
    CSFP_LINE_EXCL = 2'b10,
    CSFP_LINE_MOD = 2'b11
  } csfp_line_t;

  typedef enum logic [1:0] {
    CSFP_CYC_IDLE = 2'b00,
    CSFP_CYC_ADDR = 2'b01,
    CSFP_CYC_DATA = 2'b10
  } csfp_cyc_t;

endpackage : csfp_pkg

// ### csfp_sync_if.sv
// Carries raw pin levels into the synchroniser and clean levels back out.
// Assumes both modports sit on the same bus clock.
`timescale 1ns/10ps
interface csfp_sync_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] rawPins;
  // Net, since each lane of the synchroniser drives its own bit
  wire logic [WIDTH-1:0] cleanPins;

  modport sync (input rawPins, output cleanPins);
  modport user (output rawPins, input cleanPins);
endinterface : csfp_sync_if

// ### csfp_pin_sync.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit.
// Assumes pins are asynchronous to ref_clk; idle level of every lane is high.
`timescale 1ns/10ps
module csfp_pin_sync
  import csfp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  csfp_sync_if.sync pins
);

  // ----------------------------------------------------------------
  // Per-lane stages
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_lane
    logic stage1_ff;
    logic stage2_ff;
    logic stage3_ff;
    logic clean_ff;

    // First stage feeds only the second one
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        stage1_ff <= 1'b1;
        stage2_ff <= 1'b1;
        stage3_ff <= 1'b1;
      end else begin
        stage1_ff <= pins.rawPins[i];
        stage2_ff <= stage1_ff;
        stage3_ff <= stage2_ff;
      end
    end

    // Change is taken only once stages two and three agree
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        clean_ff <= 1'b1;
      end else if (stage2_ff == stage3_ff) begin
        clean_ff <= stage3_ff;
      end
    end

    assign pins.cleanPins[i] = clean_ff;
  end

endmodule : csfp_pin_sync

// ### csfp_cache_pin_ctrl.sv
// Cache snoop and line-fill pin control: inquire handling and fill decision.
// Assumes the far side holds pins stable around strobes; single clock.
//
// Function
// - Inquire hit leaves line Shared or Invalid per the snoop drop select.
// - Drop select and inquire address sampled in the strobe-active clock.
// - Cacheable grant decides cacheability and so the cycle length.
// - Burst fill only with line-fill intent signalled and grant active.
// - Intent without grant runs a plain single transfer.
`timescale 1ns/10ps
module csfp_cache_pin_ctrl
  import csfp_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int NUM_LINES = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic external_snoop_strobe_n,
  input wire logic snoop_drop_select,
  input wire logic [ADDR_W-1:0] snoopAddr,
  input wire logic cacheable_grant_n,
  input wire logic dataReady_n,
  input wire logic reqValid,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic reqCacheable,
  output logic busIdle_ff,
  output logic busStart_ff,
  output logic [ADDR_W-1:0] busAddr_ff,
  output logic lineFillIntent_n_ff,
  output logic cycleDone_ff,
  output logic cycleBurst_ff,
  output logic snoopDone_ff,
  output logic snoopHit_ff
);

  localparam int TAG_W = ADDR_W - LINE_OFS;
  localparam int IDX_W = (NUM_LINES > 1) ? $clog2(NUM_LINES) : 1;
  localparam int SYNC_W = ADDR_W + 4;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  csfp_sync_if #(.WIDTH(SYNC_W)) syncBus ();

  assign syncBus.rawPins = {dataReady_n, cacheable_grant_n, snoop_drop_select,
                            external_snoop_strobe_n, snoopAddr};

  csfp_pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pins(syncBus)
  );

  logic [ADDR_W-1:0] snoopAddrClean;
  logic strobeClean_n;
  logic dropClean;
  logic grantClean_n;
  logic readyClean_n;
  assign snoopAddrClean = syncBus.cleanPins[ADDR_W-1:0];
  assign strobeClean_n = syncBus.cleanPins[ADDR_W];
  assign dropClean = syncBus.cleanPins[ADDR_W+1];
  assign grantClean_n = syncBus.cleanPins[ADDR_W+2];
  assign readyClean_n = syncBus.cleanPins[ADDR_W+3];

  // ----------------------------------------------------------------
  // Line store
  // ----------------------------------------------------------------
  logic [TAG_W-1:0] lineTag_ff [NUM_LINES];
  csfp_line_t [NUM_LINES-1:0] lineState_ff;
  logic [IDX_W-1:0] victim_ff;
  logic [NUM_LINES-1:0] hitVec;
  logic [TAG_W-1:0] snoopTag;
  assign snoopTag = snoopAddrClean[ADDR_W-1:LINE_OFS];

  for (genvar i = 0; i < NUM_LINES; i++) begin : g_cmp
    assign hitVec[i] = (lineState_ff[i] != CSFP_LINE_INVALID) && (lineTag_ff[i] == snoopTag);
  end

  logic [IDX_W-1:0] hitIdx;
  always_comb begin
    hitIdx = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (hitVec[i]) begin
        hitIdx = IDX_W'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Inquire detection
  // ----------------------------------------------------------------
  logic strobePrev_ff;
  logic snoopFire;
  logic snoopDrop_ff;
  logic [IDX_W-1:0] snoopIdx_ff;
  assign snoopFire = strobePrev_ff && !strobeClean_n;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      strobePrev_ff <= 1'b1;
    end else begin
      strobePrev_ff <= strobeClean_n;
    end
  end

  // Drop select latched in the same clock as the strobe and address
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      snoopDone_ff <= 1'b0;
      snoopHit_ff <= 1'b0;
      snoopDrop_ff <= 1'b0;
      snoopIdx_ff <= '0;
    end else begin
      snoopDone_ff <= snoopFire;
      if (snoopFire) begin
        snoopHit_ff <= |hitVec;
        snoopDrop_ff <= dropClean;
        snoopIdx_ff <= hitIdx;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle engine
  // ----------------------------------------------------------------
  csfp_cyc_t cyc_ff;
  csfp_cyc_t nxt_cyc;
  logic [2:0] beat_ff;
  logic burst_ff;
  logic cacheReq_ff;
  logic lastBeat;
  logic installEn;
  logic firstBeat;

  assign firstBeat = (cyc_ff == CSFP_CYC_DATA) && !readyClean_n && (beat_ff == BEAT_ZERO);
  assign lastBeat = (cyc_ff == CSFP_CYC_DATA) && !readyClean_n
                    && (firstBeat ? !(cacheReq_ff && !grantClean_n)
                                  : (beat_ff == BURST_BEATS - 3'h1));
  assign installEn = lastBeat && burst_ff;

  always_comb begin
    nxt_cyc = cyc_ff;
    case (cyc_ff)
      CSFP_CYC_IDLE: begin
        if (reqValid) begin
          nxt_cyc = CSFP_CYC_ADDR;
        end
      end
      CSFP_CYC_ADDR: begin
        nxt_cyc = CSFP_CYC_DATA;
      end
      CSFP_CYC_DATA: begin
        if (lastBeat) begin
          nxt_cyc = CSFP_CYC_IDLE;
        end
      end
      default: begin
        nxt_cyc = CSFP_CYC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_ff <= CSFP_CYC_IDLE;
      busIdle_ff <= 1'b1;
    end else begin
      cyc_ff <= nxt_cyc;
      busIdle_ff <= (nxt_cyc == CSFP_CYC_IDLE);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busStart_ff <= 1'b0;
      busAddr_ff <= '0;
      cacheReq_ff <= 1'b0;
      lineFillIntent_n_ff <= 1'b1;
    end else begin
      busStart_ff <= (cyc_ff == CSFP_CYC_IDLE) && reqValid;
      if ((cyc_ff == CSFP_CYC_IDLE) && reqValid) begin
        busAddr_ff <= reqAddr;
        cacheReq_ff <= reqCacheable;
        lineFillIntent_n_ff <= !reqCacheable;
      end else if (lastBeat) begin
        cacheReq_ff <= 1'b0;
        lineFillIntent_n_ff <= 1'b1;
      end
    end
  end

  // Grant taken with the first ready; it fixes the cycle length
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      beat_ff <= BEAT_ZERO;
      burst_ff <= 1'b0;
      cycleDone_ff <= 1'b0;
      cycleBurst_ff <= 1'b0;
    end else begin
      cycleDone_ff <= lastBeat;
      if (lastBeat) begin
        beat_ff <= BEAT_ZERO;
        burst_ff <= 1'b0;
        cycleBurst_ff <= burst_ff;
      end else if (firstBeat) begin
        beat_ff <= beat_ff + 3'h1;
        burst_ff <= cacheReq_ff && !grantClean_n;
      end else if ((cyc_ff == CSFP_CYC_DATA) && !readyClean_n) begin
        beat_ff <= beat_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Line state update
  // ----------------------------------------------------------------
  // Snoop applied after install so a same-cycle inquire hit on the victim line overrides the install
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lineState_ff <= '{default: CSFP_LINE_INVALID};
      victim_ff <= '0;
    end else begin
      if (installEn) begin
        lineState_ff[victim_ff] <= CSFP_LINE_EXCL;
        victim_ff <= (victim_ff == IDX_W'(NUM_LINES - 1)) ? '0 : victim_ff + 1'b1;
      end
      if (snoopFire && (|hitVec)) begin
        lineState_ff[hitIdx] <= dropClean ? CSFP_LINE_INVALID
                                          : CSFP_LINE_SHARED;
      end
    end
  end

  // Tags need no reset; state guards them
  always_ff @(posedge ref_clk) begin
    if (installEn) begin
      lineTag_ff[victim_ff] <= busAddr_ff[ADDR_W-1:LINE_OFS];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic anyHit;
  logic fillGranted;
  assign anyHit = |hitVec;
  assign fillGranted = cacheReq_ff && !lineFillIntent_n_ff && !grantClean_n;

  chk_snoop_final_state: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    snoopDone_ff && snoopHit_ff && !$past(installEn)
    |-> lineState_ff[snoopIdx_ff] == (snoopDrop_ff ? CSFP_LINE_INVALID : CSFP_LINE_SHARED))
    else $error("Inquire hit left wrong line state");

  chk_snoop_same_clock: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    snoopFire |=> snoopDone_ff && (snoopDrop_ff == $past(dropClean))
                  && (snoopHit_ff == $past(anyHit)))
    else $error("Drop select not taken with the strobe");

  chk_grant_length: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    firstBeat && cacheReq_ff && !grantClean_n |=> !cycleDone_ff && burst_ff)
    else $error("Granted cacheable cycle ended early");

  chk_burst_cause: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(burst_ff) |-> $past(fillGranted))
    else $error("Burst started without intent and grant");

  chk_ungranted_single: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    firstBeat && !lineFillIntent_n_ff && grantClean_n |=> cycleDone_ff && !cycleBurst_ff)
    else $error("Ungranted cycle was not a single transfer");

  chk_miss_no_change: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    snoopFire && !(|hitVec) && !installEn |=> $stable(lineState_ff))
    else $error("Inquire miss changed a line");

endmodule : csfp_cache_pin_ctrl

// ### csfp_far_side.sv
// Far-side memory model: answers each bus cycle with ready and grant.
// Assumes the block's start and done pulses; the bench picks the grant.
`timescale 1ns/10ps
module csfp_far_side (
  input wire logic ref_clk,
  input wire logic busStart,
  input wire logic cycleDone,
  input wire logic grantOn,
  output logic cacheable_grant_n = 1'b1,
  output logic dataReady_n = 1'b1
);
  // ----------------------------------------------------------------
  // Ready and grant pins
  // ----------------------------------------------------------------
  // Ready held until done: the pin filter drops one-cycle pulses
  always @(negedge ref_clk) begin
    if (busStart) begin
      dataReady_n <= 1'b0;
      cacheable_grant_n <= ~grantOn;
    end else if (cycleDone) begin
      // Released pins fall back to their pulled-up idle level
      dataReady_n <= 1'b1;
      cacheable_grant_n <= 1'b1;
    end
  end
endmodule : csfp_far_side

// ### csfp_cache_pin_ctrl_tb_top.sv
// Self-checking bench for the snoop and line-fill pin control.
// Assumes the far-side model answers cycles; snoop pins come from here.
`timescale 1ns/10ps
module csfp_cache_pin_ctrl_tb_top;
  logic ref_clk = 1'b0;
  logic reset_n;
  logic external_snoop_strobe_n;
  logic snoop_drop_select;
  logic [31:0] snoopAddr;
  logic cacheable_grant_n;
  logic dataReady_n;
  logic reqValid;
  logic [31:0] reqAddr;
  logic reqCacheable;
  logic busIdle;
  logic busStart;
  logic [31:0] busAddr;
  logic fillIntent_n;
  logic cycleDone;
  logic cycleBurst;
  logic snoopDone;
  logic snoopHit;
  logic grantOn;
  int badCount = 0;
  int comparisons = 0;
  int cycles = 0;

  always #2 ref_clk = ~ref_clk;

  csfp_cache_pin_ctrl i_csfp_cache_pin_ctrl (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .external_snoop_strobe_n(external_snoop_strobe_n),
    .snoop_drop_select(snoop_drop_select), .snoopAddr(snoopAddr),
    .cacheable_grant_n(cacheable_grant_n), .dataReady_n(dataReady_n),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqCacheable(reqCacheable),
    .busIdle_ff(busIdle), .busStart_ff(busStart), .busAddr_ff(busAddr),
    .lineFillIntent_n_ff(fillIntent_n), .cycleDone_ff(cycleDone),
    .cycleBurst_ff(cycleBurst), .snoopDone_ff(snoopDone), .snoopHit_ff(snoopHit)
  );

  csfp_far_side i_csfp_far_side (
    .ref_clk(ref_clk), .busStart(busStart), .cycleDone(cycleDone),
    .grantOn(grantOn), .cacheable_grant_n(cacheable_grant_n),
    .dataReady_n(dataReady_n)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check

  task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : checkWord

  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : giveVerdict

  task automatic busCycle(input logic [31:0] a, input logic cach, input logic gr,
                          input logic expBurst);
    int n;
    grantOn = gr;
    reqAddr = a;
    reqCacheable = cach;
    reqValid = 1'b1;
    n = 0;
    do begin @(negedge ref_clk); n++; end while (busStart !== 1'b1 && n < 20);
    reqValid = 1'b0;
    check("bus start", 1'b1, busStart);
    check("bus busy", 1'b0, busIdle);
    checkWord("bus address", a, busAddr);
    check("fill intent", ~cach, fillIntent_n);
    n = 0;
    do begin @(negedge ref_clk); n++; end while (cycleDone !== 1'b1 && n < 40);
    check("cycle done", 1'b1, cycleDone);
    check("burst fill", expBurst, cycleBurst);
    check("bus idle", 1'b1, busIdle);
    check("intent released", 1'b1, fillIntent_n);
    // Let the filtered ready settle back to idle
    repeat (8) @(negedge ref_clk);
  endtask : busCycle

  task automatic snoop(input logic [31:0] a, input logic drop, input logic expHit);
    int n;
    snoopAddr = a;
    snoop_drop_select = drop;
    external_snoop_strobe_n = 1'b0;
    n = 0;
    do begin @(negedge ref_clk); n++; end while (snoopDone !== 1'b1 && n < 20);
    check("snoop done", 1'b1, snoopDone);
    check("snoop hit", expHit, snoopHit);
    // Released pins no longer show the old address or select
    external_snoop_strobe_n = 1'b1;
    snoopAddr = ~a;
    snoop_drop_select = ~drop;
    @(negedge ref_clk);
    check("snoop pulse", 1'b0, snoopDone);
    repeat (5) @(negedge ref_clk);
  endtask : snoop

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic scnFillAndSnoop();
    busCycle(32'h0000_1040, 1'b1, 1'b1, 1'b1);
    snoop(32'h0000_1040, 1'b0, 1'b1);
    snoop(32'h0000_105c, 1'b1, 1'b1);
    snoop(32'h0000_1048, 1'b0, 1'b0);
  endtask : scnFillAndSnoop

  task automatic scnNoGrant();
    busCycle(32'h0000_2080, 1'b1, 1'b0, 1'b0);
    snoop(32'h0000_2080, 1'b0, 1'b0);
  endtask : scnNoGrant

  task automatic scnUncached();
    busCycle(32'h0000_30c0, 1'b0, 1'b1, 1'b0);
    snoop(32'h0000_30c0, 1'b0, 1'b0);
  endtask : scnUncached

  task automatic scnMissIgnored();
    busCycle(32'h0000_4100, 1'b1, 1'b1, 1'b1);
    snoop(32'h0000_4120, 1'b1, 1'b0);
    snoop(32'h0000_4100, 1'b0, 1'b1);
  endtask : scnMissIgnored

  // Mid-run reset must clear outputs and drop every line
  task automatic scnMidReset();
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("reset idle", 1'b1, busIdle);
    check("reset start", 1'b0, busStart);
    checkWord("reset address", 32'h0, busAddr);
    check("reset intent", 1'b1, fillIntent_n);
    check("reset done", 1'b0, cycleDone);
    check("reset burst", 1'b0, cycleBurst);
    check("reset snoop", 1'b0, snoopDone);
    check("reset hit", 1'b0, snoopHit);
    reset_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    snoop(32'h0000_4100, 1'b0, 1'b0);
  endtask : scnMidReset

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      giveVerdict();
    end
  end

  initial begin
    reset_n = 1'b0;
    external_snoop_strobe_n = 1'b1;
    snoop_drop_select = 1'b0;
    snoopAddr = 32'h0;
    reqValid = 1'b0;
    reqAddr = 32'h0;
    reqCacheable = 1'b0;
    grantOn = 1'b0;
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    scnFillAndSnoop();
    scnNoGrant();
    scnUncached();
    scnMissIgnored();
    scnMidReset();
    giveVerdict();
  end
endmodule : csfp_cache_pin_ctrl_tb_top
